// [amd_defs.svh]
`ifndef AMD_DEFS_SVH
`define AMD_DEFS_SVH

// ------------------------------------------------------------
// Address map constants
// ------------------------------------------------------------
`define AMD_IO_LO 16'h0000
`define AMD_IO_HI 16'h007f
`define AMD_PS_MIRROR 16'h0078
`define AMD_XIO_LO 16'h0f80
`define AMD_XIO_HI 16'h0fff
`define AMD_RAM_LO 16'h0090
`define AMD_RAM_TOP_S 16'h027f
`define AMD_RAM_TOP_M 16'h047f
`define AMD_RAM_TOP_L 16'h087f
`define AMD_ROM_LO_S 16'hb000
`define AMD_ROM_LO_M 16'h7000
`define AMD_ROM_LO_L 16'h1000
`define AMD_NVS_LO 16'hffbc
`define AMD_NVS_HI 16'hffbf
`define AMD_VEC_LO 16'hffc0
`define AMD_SEC_ADDR 16'hfffc
`define AMD_MODE_ADDR 16'hfffd
`define AMD_RSTV_HI_ADDR 16'hfffe
`define AMD_RSTV_LO_ADDR 16'hffff
`define AMD_GPR_PAGE 8'h01
`define AMD_DIR_BASE 16'h0080
`define AMD_MODE_SINGLE 8'h00
`define AMD_VACANT_DATA 8'hff
`define AMD_RP_RST 5'h00
`define AMD_DP_RST 3'h0

`endif

// [amd_pkg.sv]
package amd_pkg;

	// Addressing kind used by the CPU for one access.
	typedef enum logic [1:0] {
		AMD_AM_LINEAR = 2'h0,
		AMD_AM_DIRECT = 2'h1,
		AMD_AM_GPR = 2'h2
	} amd_am_t;

	// One CPU access request.
	typedef struct packed {
		logic valid;
		logic wr;
		amd_am_t mode;
		logic [15:0] addr;
		logic [7:0] wdata;
	} amd_req_t;

	// Region select, at most one of the first five bits is set.
	typedef struct packed {
		logic io;
		logic xio;
		logic ram;
		logic rom;
		logic ps;
		logic nvs;
		logic sec;
		logic vec;
	} amd_sel_t;

	// Reset fetch sequencer states.
	typedef enum logic [4:0] {
		AMD_ST_MODE = 5'h01,
		AMD_ST_VHI = 5'h02,
		AMD_ST_VLO = 5'h04,
		AMD_ST_CAP = 5'h08,
		AMD_ST_RUN = 5'h10
	} amd_state_t;

endpackage : amd_pkg

// [amd_decoder.sv]
`timescale 1ns/100ps
`include "amd_defs.svh"
// Behaviour
// - One 64 Kbyte space, four region kinds.
// - 0000-007F peripherals, linear and direct reachable.
// - 0F80-0FFF peripherals, linear access only.
// - Direct reaches RAM 0090-00FF with the direct bank pointer at 0.
// - Banked direct reaches up to 027F/047F.
// - Large variant 0480-087F beyond direct reach.
// - 0100-01FF register banks, also plain RAM.
// - Register addressing reaches banks by short opcode.
// - FFC0-FFFF is the vector table.
// - FFFC is the flash security byte.
// - FFBC-FFBF hold nonvolatile settings store data.
// - Single-chip only, never an external cycle.
// - After reset: mode byte, vector, then run.
// - RAM size 496/1008/2032 by variant.
// - Program counter resets to FFFD.
// - Bank address is 01, pointer, opcode bits.
// - Bank pointers mirrored at I/O address 0078.
module amd_decoder #(
	parameter int VARIANT = 2
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset,
	// CPU access
	input wire amd_pkg::amd_req_t i_req,
	// Read data from targets, valid in the same cycle as their select
	input wire logic [7:0] i_io_rdata,
	input wire logic [7:0] i_ram_rdata,
	input wire logic [7:0] i_rom_rdata,
	// Target side
	output amd_pkg::amd_sel_t o_sel,
	output logic [15:0] o_addr,
	output logic o_wr,
	output logic [7:0] o_wdata,
	// Read answer to the CPU
	output logic o_rvalid,
	output logic [7:0] o_rdata,
	// Reset fetch and CPU state
	output logic o_ready,
	output logic [15:0] o_program_counter,
	output logic o_mode_err,
	output logic [4:0] o_register_bank_pointer,
	output logic [2:0] o_direct_bank_pointer
);

	// ------------------------------------------------------------
	// Decode functions
	// ------------------------------------------------------------

	// Effective address for each addressing kind.
	function automatic logic [15:0] eff_addr(input amd_pkg::amd_am_t m, input logic [15:0] a,
		input logic [4:0] rp, input logic [2:0] dp);
		logic [15:0] r;
		r = a;
		case (m)
			amd_pkg::AMD_AM_GPR: r = {`AMD_GPR_PAGE, rp, a[2:0]};
			amd_pkg::AMD_AM_DIRECT: r = a[7] ? ({5'h00, dp, a[6:0]} + `AMD_DIR_BASE)
				: {8'h00, a[7:0]};
			default: r = a;
		endcase
		return r;
	endfunction : eff_addr

	// Region select for an effective address; uncovered holes select nothing.
	function automatic amd_pkg::amd_sel_t decode(input logic [15:0] a);
		amd_pkg::amd_sel_t s;
		logic [15:0] top;
		logic [15:0] rom_lo;
		s = '0;
		// Variant sets RAM top and ROM base
		top = (VARIANT == 0) ? `AMD_RAM_TOP_S : (VARIANT == 1) ? `AMD_RAM_TOP_M : `AMD_RAM_TOP_L;
		rom_lo = (VARIANT == 0) ? `AMD_ROM_LO_S : (VARIANT == 1) ? `AMD_ROM_LO_M : `AMD_ROM_LO_L;
		if (a == `AMD_PS_MIRROR) begin
			s.ps = 1'b1;
		end else if (a <= `AMD_IO_HI) begin
			s.io = 1'b1;
		end else if (a >= `AMD_RAM_LO && a <= top) begin
			// Register banks are ordinary RAM here
			s.ram = 1'b1;
		end else if (a >= `AMD_XIO_LO && a <= `AMD_XIO_HI) begin
			s.xio = 1'b1;
		end else if (a >= rom_lo) begin
			s.rom = 1'b1;
		end
		s.nvs = (a >= `AMD_NVS_LO && a <= `AMD_NVS_HI);
		s.vec = (a >= `AMD_VEC_LO);
		s.sec = (a == `AMD_SEC_ADDR);
		return s;
	endfunction : decode

	// ------------------------------------------------------------
	// Request path
	// ------------------------------------------------------------
	amd_pkg::amd_state_t state_r;
	logic [4:0] rp_r;
	logic [2:0] dp_r;
	logic [15:0] ea;
	amd_pkg::amd_sel_t sel_c;
	logic take;
	logic [15:0] boot_addr;
	logic boot_rd;
	logic rd_pend_r;
	amd_pkg::amd_sel_t rd_sel_r;

	// Direct addressing only reaches the low area, so 0F80 and above stay out of its reach.
	always_comb begin
		ea = eff_addr(i_req.mode, i_req.addr, rp_r, dp_r);
		sel_c = decode(ea);
		take = i_req.valid && (state_r == amd_pkg::AMD_ST_RUN);
		boot_rd = (state_r == amd_pkg::AMD_ST_MODE) || (state_r == amd_pkg::AMD_ST_VHI)
			|| (state_r == amd_pkg::AMD_ST_VLO);
		case (state_r)
			amd_pkg::AMD_ST_MODE: boot_addr = `AMD_MODE_ADDR;
			amd_pkg::AMD_ST_VHI: boot_addr = `AMD_RSTV_HI_ADDR;
			default: boot_addr = `AMD_RSTV_LO_ADDR;
		endcase
	end

	// Target strobes; nothing is ever driven off chip, so every access ends inside.
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			o_sel <= '0;
			o_addr <= 16'h0000;
			o_wr <= 1'b0;
			o_wdata <= 8'h00;
		end else if (boot_rd) begin
			o_sel <= decode(boot_addr);
			o_addr <= boot_addr;
			o_wr <= 1'b0;
			o_wdata <= 8'h00;
		end else if (take) begin
			// Only internal targets, ROM never written
			o_sel <= sel_c;
			o_addr <= ea;
			o_wr <= i_req.wr && (sel_c.io || sel_c.xio || sel_c.ram);
			o_wdata <= i_req.wdata;
		end else begin
			o_sel <= '0;
			o_wr <= 1'b0;
		end
	end

	// Read tracking: the answer is formed one cycle after the select.
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			rd_pend_r <= 1'b0;
			rd_sel_r <= '0;
		end else begin
			rd_pend_r <= take && !i_req.wr;
			rd_sel_r <= take ? sel_c : '0;
		end
	end

	// Read answer mux; holes give a fixed value so software sees the same byte every time.
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			o_rvalid <= 1'b0;
			o_rdata <= 8'h00;
		end else begin
			o_rvalid <= rd_pend_r;
			if (rd_pend_r) begin
				if (rd_sel_r.io || rd_sel_r.xio) begin
					o_rdata <= i_io_rdata;
				end else if (rd_sel_r.ram) begin
					o_rdata <= i_ram_rdata;
				end else if (rd_sel_r.rom) begin
					o_rdata <= i_rom_rdata;
				end else if (rd_sel_r.ps) begin
					o_rdata <= {o_register_bank_pointer, o_direct_bank_pointer};
				end else begin
					o_rdata <= `AMD_VACANT_DATA;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Bank pointers
	// ------------------------------------------------------------

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			rp_r <= `AMD_RP_RST;
			dp_r <= `AMD_DP_RST;
		end else if (take && i_req.wr && sel_c.ps) begin
			rp_r <= i_req.wdata[7:3];
			dp_r <= i_req.wdata[2:0];
		end
	end

	// The pointer outputs are registered copies so they leave straight from a flop.
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			o_register_bank_pointer <= `AMD_RP_RST;
			o_direct_bank_pointer <= `AMD_DP_RST;
		end else if (take && i_req.wr && sel_c.ps) begin
			o_register_bank_pointer <= i_req.wdata[7:3];
			o_direct_bank_pointer <= i_req.wdata[2:0];
		end
	end

	// ------------------------------------------------------------
	// Reset fetch sequencer
	// ------------------------------------------------------------

	// Mode byte, vector high, vector low, capture, run
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			state_r <= amd_pkg::AMD_ST_MODE;
		end else begin
			case (state_r)
				amd_pkg::AMD_ST_MODE: state_r <= amd_pkg::AMD_ST_VHI;
				amd_pkg::AMD_ST_VHI: state_r <= amd_pkg::AMD_ST_VLO;
				amd_pkg::AMD_ST_VLO: state_r <= amd_pkg::AMD_ST_CAP;
				amd_pkg::AMD_ST_CAP: state_r <= amd_pkg::AMD_ST_RUN;
				amd_pkg::AMD_ST_RUN: state_r <= amd_pkg::AMD_ST_RUN;
				default: state_r <= amd_pkg::AMD_ST_MODE;
			endcase
		end
	end

	// Counter starts at the mode byte address
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			o_program_counter <= `AMD_MODE_ADDR;
			o_mode_err <= 1'b0;
			o_ready <= 1'b0;
		end else begin
			case (state_r)
				amd_pkg::AMD_ST_VHI: begin
					o_mode_err <= (i_rom_rdata != `AMD_MODE_SINGLE);
					o_program_counter <= `AMD_RSTV_HI_ADDR;
				end
				amd_pkg::AMD_ST_VLO: o_program_counter <= {i_rom_rdata, 8'h00};
				amd_pkg::AMD_ST_CAP: begin
					o_program_counter <= {o_program_counter[15:8], i_rom_rdata};
					o_ready <= 1'b1;
				end
				default: o_ready <= (state_r == amd_pkg::AMD_ST_RUN);
			endcase
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	AST_ONE_REGION: assert property (
		$onehot0({o_sel.io, o_sel.xio, o_sel.ram, o_sel.rom, o_sel.ps}))
		else $error("More than one region selected.");
	AST_IO_LINEAR: assert property (
		take && i_req.mode == amd_pkg::AMD_AM_LINEAR && i_req.addr <= 16'h007f
		&& i_req.addr != 16'h0078 |=> o_sel.io && o_addr == $past(i_req.addr))
		else $error("I/O access not routed.");
	AST_XIO_NOT_DIRECT: assert property (
		take && i_req.mode == amd_pkg::AMD_AM_DIRECT |=> !o_sel.xio)
		else $error("Direct access reached extended I/O.");
	AST_DIRECT_BANK: assert property (
		take && i_req.mode == amd_pkg::AMD_AM_DIRECT && i_req.addr[7]
		|=> o_addr == {5'h00, $past(dp_r), $past(i_req.addr[6:0])} + 16'h0080)
		else $error("Direct bank address wrong.");
	AST_DIRECT_REACH: assert property (
		take && i_req.mode == amd_pkg::AMD_AM_DIRECT |=> o_addr <= 16'h047f)
		else $error("Direct access beyond bank window.");
	AST_GPR_ADDR: assert property (
		take && i_req.mode == amd_pkg::AMD_AM_GPR
		|=> o_addr == {8'h01, $past(rp_r), $past(i_req.addr[2:0])} && o_sel.ram)
		else $error("Register bank address wrong.");
	AST_VACANT_READ: assert property (
		take && !i_req.wr && sel_c == '0 |=> ##1 o_rvalid && o_rdata == 8'hff)
		else $error("Vacant read value wrong.");
	AST_ROM_NO_WRITE: assert property (
		o_wr |-> (o_sel.io || o_sel.xio || o_sel.ram))
		else $error("Write to a non-writable target.");
	AST_BOOT_ORDER: assert property (
		state_r == amd_pkg::AMD_ST_MODE |=> o_addr == 16'hfffd ##1 o_addr == 16'hfffe
		##1 o_addr == 16'hffff ##1 o_ready)
		else $error("Reset fetch order wrong.");
	AST_MIRROR_READ: assert property (
		take && !i_req.wr && sel_c.ps |=> ##1 o_rdata == {rp_r, dp_r})
		else $error("Mirror read wrong.");

	COV_BOOT_DONE: cover property ($rose(o_ready));
	COV_GPR_ACCESS: cover property (take && i_req.mode == amd_pkg::AMD_AM_GPR);
	COV_MIRROR_WRITE: cover property (take && i_req.wr && sel_c.ps);
	COV_VACANT: cover property (take && sel_c == '0);

endmodule : amd_decoder

// [amd_tgt_model.sv]
`timescale 1ns/100ps
module amd_tgt_model (
	// Clock
	input wire logic i_core_clk,
	// Decoder target side
	input wire amd_pkg::amd_sel_t i_sel,
	input wire logic [15:0] i_addr,
	input wire logic i_wr,
	input wire logic [7:0] i_wdata,
	// Read data to the decoder
	output logic [7:0] o_io_rdata,
	output logic [7:0] o_ram_rdata,
	output logic [7:0] o_rom_rdata
);
	logic [7:0] mem [0:65535];
	logic [7:0] spin_r;

	// Preload every byte with a known pattern and the boot bytes.
	initial begin
		spin_r = 8'h00;
		for (int a = 0; a < 65536; a++) begin
			mem[a] = a[7:0] ^ a[15:8] ^ 8'h3c;
		end
		mem[16'hfffd] = 8'h00;
		mem[16'hfffe] = 8'h12;
		mem[16'hffff] = 8'h34;
	end

	// Unselected targets show a moving pattern, so a stale byte never passes.
	always @(posedge i_core_clk) begin
		spin_r <= spin_r + 8'h3b;
		if (i_wr && (i_sel.io || i_sel.xio || i_sel.ram)) begin
			mem[i_addr] <= i_wdata;
		end
	end

	// Read data follows the address while the target is selected.
	assign o_io_rdata = (i_sel.io || i_sel.xio) ? mem[i_addr] : spin_r;
	assign o_ram_rdata = i_sel.ram ? mem[i_addr] : ~spin_r;
	assign o_rom_rdata = i_sel.rom ? mem[i_addr] : spin_r ^ 8'h5a;
endmodule : amd_tgt_model

// [address_map_decoder_bench.sv]
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
	$display("wrong value at %0t: got %h want %h", $time, a, b); end end
module address_map_decoder_bench;
	logic i_core_clk;
	logic i_reset;
	amd_pkg::amd_req_t i_req;
	amd_pkg::amd_sel_t o_sel;
	logic [15:0] o_addr;
	logic o_wr;
	logic [7:0] o_wdata;
	logic o_rvalid;
	logic [7:0] o_rdata;
	logic o_ready;
	logic [15:0] o_program_counter;
	logic o_mode_err;
	logic [4:0] o_register_bank_pointer;
	logic [2:0] o_direct_bank_pointer;
	logic [7:0] io_rd;
	logic [7:0] ram_rd;
	logic [7:0] rom_rd;
	int num_errors = 0;
	int compares = 0;
	logic [31:0] seed = 32'hddd4;
	logic [7:0] expq [$];
	logic [7:0] sh [logic [15:0]];
	logic [7:0] mon_e;
	logic [7:0] d;
	localparam logic [15:0] RA [13] = '{16'h0000, 16'h007f, 16'h0f80, 16'h0fff, 16'h0090,
		16'h087f, 16'h0080, 16'h0880, 16'h0f7f, 16'h1000, 16'hffbc, 16'hffc0, 16'hfffc};
	localparam logic [7:0] RS [13] = '{8'h80, 8'h80, 8'h40, 8'h40, 8'h20, 8'h20, 8'h00,
		8'h00, 8'h00, 8'h10, 8'h14, 8'h11, 8'h13};

	amd_decoder #(.VARIANT(2)) uut (.i_core_clk(i_core_clk), .i_reset(i_reset),
		.i_req(i_req), .i_io_rdata(io_rd), .i_ram_rdata(ram_rd), .i_rom_rdata(rom_rd),
		.o_sel(o_sel), .o_addr(o_addr), .o_wr(o_wr), .o_wdata(o_wdata),
		.o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_ready(o_ready),
		.o_program_counter(o_program_counter), .o_mode_err(o_mode_err),
		.o_register_bank_pointer(o_register_bank_pointer),
		.o_direct_bank_pointer(o_direct_bank_pointer));
	amd_tgt_model tgt (.i_core_clk(i_core_clk), .i_sel(o_sel), .i_addr(o_addr),
		.i_wr(o_wr), .i_wdata(o_wdata), .o_io_rdata(io_rd), .o_ram_rdata(ram_rd),
		.o_rom_rdata(rom_rd));

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// Expected byte: last write seen by the bench, else the preload pattern.
	function logic [7:0] exp_of(input logic [15:0] a);
		return sh.exists(a) ? sh[a] : (a[7:0] ^ a[15:8] ^ 8'h3c);
	endfunction : exp_of

	// One access; reads leave their expected byte for the watcher.
	task acc(input logic w, input amd_pkg::amd_am_t md, input logic [15:0] a,
			input logic [7:0] wd, input logic [7:0] es, input logic [15:0] ea,
			input logic [7:0] ed);
		@(posedge i_core_clk);
		#1 i_req = '{valid: 1'b1, wr: w, mode: md, addr: a, wdata: wd};
		@(posedge i_core_clk);
		#1;
		// The strobes stand only in the cycle after the take edge, so look there.
		`CHK(o_sel, es)
		`CHK(o_addr, ea)
		`CHK(o_wr, w && (es[7:5] != 3'h0))
		if (w && es[7:5] != 3'h0) begin
			sh[ea] = wd;
			`CHK(o_wdata, wd)
		end
		i_req.valid = 1'b0;
		if (!w) begin
			expq.push_back(ed);
		end
	endtask : acc

	task end_sim();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim

	// Clock at 100 MHz.
	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end

	// Every read answer is matched against the oldest expectation.
	always @(posedge i_core_clk) begin
		#2;
		if (o_rvalid === 1'b1) begin
			mon_e = (expq.size() != 0) ? expq.pop_front() : 8'hxx;
			`CHK(o_rdata, mon_e)
		end
	end

	// A hang anywhere still ends in the closing report.
	initial begin
		#200000;
		num_errors++;
		end_sim();
	end

	// Main scenario: boot fetch, region sweep, then pointer and bank accesses.
	initial begin
		i_reset = 1'b1;
		i_req = '0;
		repeat (8) @(posedge i_core_clk);
		`CHK(o_program_counter, 16'hfffd)
		#1 i_reset = 1'b0;
		// Boot fetches mode byte then both vector bytes.
		for (int k = 0; k < 3; k++) begin
			@(posedge i_core_clk);
			#1;
			`CHK(o_addr, 16'hfffd + 16'(k))
			`CHK(o_sel.rom, 1'b1)
		end
		@(posedge i_core_clk);
		#1;
		`CHK(o_program_counter, 16'h1234)
		`CHK(o_ready, 1'b1)
		`CHK(o_mode_err, 1'b0)
		// Region edges, vacant holes and flash tags by linear read.
		for (int k = 0; k < 13; k++) begin
			acc(1'b0, amd_pkg::AMD_AM_LINEAR, RA[k], 8'h00, RS[k], RA[k],
				(RS[k] == 8'h00) ? 8'hff : exp_of(RA[k]));
		end
		// Writes to flash and to a hole must change nothing.
		acc(1'b1, amd_pkg::AMD_AM_LINEAR, 16'h1000, 8'ha5, 8'h10, 16'h1000, 8'h00);
		acc(1'b1, amd_pkg::AMD_AM_LINEAR, 16'h0080, 8'ha5, 8'h00, 16'h0080, 8'h00);
		acc(1'b0, amd_pkg::AMD_AM_LINEAR, 16'h1000, 8'h00, 8'h10, 16'h1000, exp_of(16'h1000));
		acc(1'b0, amd_pkg::AMD_AM_LINEAR, 16'h0080, 8'h00, 8'h00, 16'h0080, 8'hff);
		acc(1'b0, amd_pkg::AMD_AM_DIRECT, 16'h0005, 8'h00, 8'h80, 16'h0005, exp_of(16'h0005));
		acc(1'b0, amd_pkg::AMD_AM_DIRECT, 16'h0095, 8'h00, 8'h20, 16'h0095, exp_of(16'h0095));
		// Random pointers through the mirror, then banked and register accesses.
		for (int k = 0; k < 4; k++) begin
			d = 8'(rnd());
			acc(1'b1, amd_pkg::AMD_AM_LINEAR, 16'h0078, d, 8'h08, 16'h0078, 8'h00);
			`CHK(o_register_bank_pointer, d[7:3])
			`CHK(o_direct_bank_pointer, d[2:0])
			acc(1'b0, amd_pkg::AMD_AM_LINEAR, 16'h0078, 8'h00, 8'h08, 16'h0078, d);
			acc(1'b0, amd_pkg::AMD_AM_DIRECT, 16'h0090, 8'h00, 8'h20,
				16'({d[2:0], 7'h10}) + 16'h0080, exp_of(16'({d[2:0], 7'h10}) + 16'h0080));
			acc(1'b1, amd_pkg::AMD_AM_GPR, 16'h0005, 8'(rnd()), 8'h20,
				{8'h01, d[7:3], 3'h5}, 8'h00);
			acc(1'b0, amd_pkg::AMD_AM_LINEAR, {8'h01, d[7:3], 3'h5}, 8'h00, 8'h20,
				{8'h01, d[7:3], 3'h5}, exp_of({8'h01, d[7:3], 3'h5}));
		end
		for (int k = 0; k < 20 && expq.size() != 0; k++) begin
			@(posedge i_core_clk);
		end
		`CHK(expq.size(), 0)
		end_sim();
	end
endmodule : address_map_decoder_bench
